// file: bench/host_port_model.sv
// host processor model driving the parallel control port
`timescale 1ns/10ps
module host_port_model (
	input wire logic sys_clk,
	output logic [7:0] bus_addr,
	output logic [7:0] bus_wdata,
	output logic bus_write,
	output logic bus_read,
	input wire logic [7:0] bus_rdata,
	input wire logic bus_rdata_valid
);
	// idle bus from time zero
	initial begin
		bus_addr = 8'h00;
		bus_wdata = 8'h00;
		bus_write = 1'b0;
		bus_read = 1'b0;
	end
	// one write strobe, data released to its inverse afterwards
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = d;
		// double-wide only with output pin in frame mode
		if (a == t1_ctrl_pkg::TX_CTRL_TWO_ADDR && (v[3] || !v[2])) begin
			v[4] = 1'b0;
		end
		@(negedge sys_clk);
		bus_addr = a;
		bus_wdata = v;
		bus_write = 1'b1;
		@(negedge sys_clk);
		bus_write = 1'b0;
		bus_wdata = ~v;
	endtask
	// one read strobe, bounded wait for the answer
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
		ok = 1'b0;
		d = 8'h00;
		// let a previous read finish its strobe; right after a write go at once
		if (bus_rdata_valid === 1'b1) begin
			@(negedge sys_clk);
		end
		bus_addr = a;
		bus_read = 1'b1;
		@(negedge sys_clk);
		bus_read = 1'b0;
		for (int i = 0; i < 4 && !ok; i++) begin
			if (bus_rdata_valid === 1'b1) begin
				d = bus_rdata;
				ok = 1'b1;
			end else begin
				@(negedge sys_clk);
			end
		end
	endtask
endmodule

// file: bench/t1_transmit_common_control_tb_top.sv
// self-checking bench for the transmit and common control bank
`timescale 1ns/10ps
module t1_transmit_common_control_tb_top;
	localparam logic [7:0] tc1 = t1_ctrl_pkg::TX_CTRL_ONE_ADDR;
	localparam logic [7:0] tc2 = t1_ctrl_pkg::TX_CTRL_TWO_ADDR;
	localparam logic [7:0] cc1 = t1_ctrl_pkg::COMMON_CTRL_ONE_ADDR;
	// bus and byte lanes
	logic sys_clk, reset_n, bus_write, bus_read, bus_rdata_valid, bus_data_oe;
	logic [7:0] bus_addr, bus_wdata, bus_rdata, tx_byte, tx_stuffed_byte;
	// pin and formatter inputs
	logic transmit_clock_input, transmit_serial_data_in, line_in_positive, line_in_negative;
	logic transmit_sync_pin_in, tx_bit_strobe, tx_frame_start, tx_multiframe_start;
	logic tx_signaling_frame, tx_line_pos, tx_line_neg, rx_recovered_pos, rx_recovered_neg;
	logic rx_serial_bit, rx_signaling_slot, yellow_alarm_request, tx_byte_valid;
	// design outputs
	logic tx_clock_from_rx, frame_bits_internal, zbtsi_en, yellow_bit2_force, yellow_sbit_f12;
	logic tx_elastic_en, rx_elastic_en, system_clock_rate_select, tx_payload_from_rx;
	logic rx_clock_from_tx, tx_serial_to_formatter, rx_line_to_framer_pos, rx_line_to_framer_neg;
	logic tx_stuffed_valid, transmit_sync_out, transmit_sync_oe, tx_sync_in_level;
	logic line_out_positive, line_out_negative, line_out_oe, receive_serial_data_out;
	logic receive_serial_oe, seen;
	logic [31:0] seed, r;
	logic [7:0] c;
	int err_total, checks_done;
	t1_transmit_common_control i_dut (.*);
	host_port_model i_host (.*);
	// free-running system clock
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	// xorshift source
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// expected stuffer byte: bit 7 forced in zero bytes with stuffing on, bit 2 cleared for yellow
	function automatic logic [7:0] exp_stuff(input logic [7:0] b, input logic z, input logic y);
		exp_stuff = b;
		if (b == 8'h00 && z) begin
			exp_stuff[t1_ctrl_pkg::BIT_SEVEN_IDX] = 1'b1;
		end
		if (y) begin
			exp_stuff[t1_ctrl_pkg::BIT_TWO_IDX] = 1'b0;
		end
	endfunction
	// closing report
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// single comparison point
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		checks_done++;
		if (s !== e) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// register read with timeout
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic ok;
		i_host.rd(a, d, ok);
		if (!ok) begin
			err_total++;
			give_verdict();
		end
		chk(d, e);
	endtask
	// one bit strobe with boundary flags
	task automatic strobe(input logic fs, input logic ms);
		@(negedge sys_clk);
		{tx_bit_strobe, tx_frame_start, tx_multiframe_start} = {1'b1, fs, ms};
		@(negedge sys_clk);
		{tx_bit_strobe, tx_frame_start, tx_multiframe_start} = 3'h0;
	endtask
	// main sequence
	initial begin
		{transmit_clock_input, transmit_serial_data_in, line_in_positive, line_in_negative} = 4'h0;
		{transmit_sync_pin_in, tx_bit_strobe, tx_frame_start, tx_multiframe_start} = 4'h0;
		{tx_signaling_frame, tx_line_pos, tx_line_neg, rx_recovered_pos} = 4'h0;
		{rx_recovered_neg, rx_serial_bit, rx_signaling_slot} = 3'h0;
		{yellow_alarm_request, tx_byte_valid} = 2'h0;
		tx_byte = 8'h00;
		reset_n = 1'b0;
		seed = 32'hace05720;
		err_total = 0;
		checks_done = 0;
		repeat (8) @(posedge sys_clk);
		@(negedge sys_clk);
		reset_n = 1'b1;
		// reset state and unmapped place
		for (int a = 8'h35; a < 8'h38; a++) begin
			rdc(8'(a), t1_ctrl_pkg::REG_RESET);
		end
		chk(frame_bits_internal, 1'b1);
		i_host.wr(8'h38, 8'hff);
		rdc(8'h38, t1_ctrl_pkg::UNMAPPED_READ);
		// common control fields, loopbacks and receive forcing
		for (int i = 0; i < 12; i++) begin
			r = rnd();
			c = (i == 0) ? 8'h51 : r[23:16];
			i_host.wr(cc1, c);
			rdc(cc1, c);
			{line_in_positive, line_in_negative, tx_line_pos, tx_line_neg, rx_recovered_pos} = r[4:0];
			{rx_recovered_neg, transmit_serial_data_in, rx_serial_bit} = r[7:5];
			{rx_signaling_slot, transmit_sync_pin_in} = r[9:8];
			repeat (4) @(negedge sys_clk);
			chk(tx_elastic_en, c[7]);
			chk(rx_elastic_en, c[2]);
			chk(system_clock_rate_select, c[3]);
			chk({tx_payload_from_rx, tx_clock_from_rx}, {2{c[1]}});
			chk(rx_clock_from_tx, c[0]);
			chk(rx_line_to_framer_pos, (c[6] | c[0]) ? tx_line_pos : line_in_positive);
			chk(rx_line_to_framer_neg, (c[6] | c[0]) ? tx_line_neg : line_in_negative);
			chk(tx_serial_to_formatter, (c[4] | c[1]) ? 1'b0 : transmit_serial_data_in);
			chk(receive_serial_data_out, (rx_signaling_slot & c[5]) | rx_serial_bit);
			chk(tx_sync_in_level, transmit_sync_pin_in);
			if (c[4] || !c[0]) begin
				chk(line_out_positive, c[4] ? rx_recovered_pos : tx_line_pos);
			end else begin
				chk(line_out_positive ^ line_out_negative, 1'b1);
			end
		end
		i_host.wr(cc1, 8'h00);
		// transmit control two fields and the byte stuffer
		for (int i = 0; i < 10; i++) begin
			r = rnd();
			c = {2'h0, r[21:16]};
			c[4] = c[4] & c[2] & ~c[3];
			c[0] = c[0] | (i == 0); // first zero byte always with stuffing on
			i_host.wr(tc2, c);
			yellow_alarm_request = r[8];
			tx_byte = (i < 4) ? 8'h00 : r[31:24];
			repeat (3) @(negedge sys_clk);
			rdc(tc2, c);
			chk(zbtsi_en, c[5]);
			chk(transmit_sync_oe, c[2]);
			chk({yellow_bit2_force, yellow_sbit_f12}, {r[8] & ~c[1], r[8] & c[1]});
			tx_byte_valid = 1'b1;
			@(negedge sys_clk);
			tx_byte_valid = 1'b0;
			seen = 1'b0;
			for (int k = 0; k < 3 && !seen; k++) begin
				if (tx_stuffed_valid === 1'b1) begin
					seen = 1'b1;
					chk(tx_stuffed_byte, exp_stuff(tx_byte, c[0], r[8] & ~c[1]));
				end else begin
					@(negedge sys_clk);
				end
			end
			if (!seen) begin
				err_total++;
				give_verdict();
			end
		end
		// sync pulse: frame mode, double-wide, multiframe mode
		yellow_alarm_request = 1'b0;
		i_host.wr(tc2, 8'h14);
		for (int w = 0; w < 2; w++) begin
			tx_signaling_frame = w[0];
			strobe(1'b1, 1'b0);
			repeat (2) @(negedge sys_clk);
			chk(transmit_sync_out, 1'b1);
			strobe(1'b0, 1'b0);
			repeat (2) @(negedge sys_clk);
			chk(transmit_sync_out, w[0]);
			strobe(1'b0, 1'b0);
		end
		i_host.wr(tc2, 8'h0c);
		strobe(1'b1, 1'b0);
		repeat (2) @(negedge sys_clk);
		chk(transmit_sync_out, 1'b0);
		strobe(1'b0, 1'b1);
		repeat (2) @(negedge sys_clk);
		chk(transmit_sync_out, 1'b1);
		strobe(1'b0, 1'b0);
		// output pin test modes
		for (int m = 1; m < 4; m++) begin
			i_host.wr(tc2, {m[1:0], 6'h04});
			repeat (3) @(negedge sys_clk);
			chk({line_out_oe, receive_serial_oe, transmit_sync_oe}, {3{m != 1}});
			if (m != 1) begin
				chk({line_out_positive, line_out_negative}, {2{m == 3}});
				chk({receive_serial_data_out, transmit_sync_out}, {2{m == 3}});
			end
			rdc(tc2, {m[1:0], 6'h04});
			chk(bus_data_oe, m != 1);
		end
		i_host.wr(tc2, 8'h00);
		// transmit clock fallback
		i_host.wr(tc1, 8'hc0);
		repeat (20) begin
			@(negedge sys_clk);
			transmit_clock_input = ~transmit_clock_input;
		end
		chk({tx_clock_from_rx, frame_bits_internal}, 8'h00);
		repeat (70) @(negedge sys_clk);
		chk(tx_clock_from_rx, 1'b1);
		i_host.wr(tc1, 8'h00);
		repeat (3) @(negedge sys_clk);
		chk({tx_clock_from_rx, frame_bits_internal}, 8'h01);
		give_verdict();
	end
endmodule

// file: src/t1_ctrl_pkg.sv
// constants, field positions and enumerations for the transmit/common control bank
// Summary of operation
// [R1] fallback bit switches formatter to receive clock
// [R2] frame bits generated internally when passthru clear
// [R3] zero byte interchange enable gates transmit processing
// [R4] double-wide sync pulse in signaling frames
// [R5] host keeps double-wide clear in multiframe/input
// [R6] sync mode selects frame or multiframe boundaries
// [R7] sync direction selects pin input or output
// [R8] yellow style selects bit two or frame twelve
// [R9] bit seven forced high in all-zero bytes
// [R10] test mode 00 normal, 01 all tristate
// [R11] test mode 10 drives low, 11 high
// [R12] transmit elastic store bypassed or inserted
// [R13] receive elastic store bypassed or inserted
// [R14] receive signaling bits forced to ones
// [R15] host sets clock rate select per backplane
// [R16] local loopback replaces line input with transmit
// [R17] remote loopback resends recovered line data
// [R18] payload loopback loops payload, receive clock transmits
// [R19] framer loopback loops transmit, sends unframed ones
// [R20] registers store full byte and read back
package t1_ctrl_pkg;
	// register byte addresses on the parallel control port
	localparam logic [7:0] TX_CTRL_ONE_ADDR = 8'h35;
	localparam logic [7:0] TX_CTRL_TWO_ADDR = 8'h36;
	localparam logic [7:0] COMMON_CTRL_ONE_ADDR = 8'h37;
	// reset and unmapped read values
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
	// transmit control one fields
	localparam int TC1_CLOCK_FALLBACK = 7;
	localparam int TC1_FRAME_PASSTHRU = 6;
	// transmit control two fields
	localparam int TC2_TEST_HI = 7;
	localparam int TC2_TEST_LO = 6;
	localparam int TC2_ZBTSI = 5;
	localparam int TC2_SYNC_DOUBLE = 4;
	localparam int TC2_SYNC_MODE = 3;
	localparam int TC2_SYNC_DIR = 2;
	localparam int TC2_YELLOW_STYLE = 1;
	localparam int TC2_B7_SUPPRESS = 0;
	// common control one fields
	localparam int CC1_TX_ELASTIC = 7;
	localparam int CC1_LOCAL_LOOP = 6;
	localparam int CC1_RX_SIG_ONES = 5;
	localparam int CC1_REMOTE_LOOP = 4;
	localparam int CC1_CLOCK_RATE = 3;
	localparam int CC1_RX_ELASTIC = 2;
	localparam int CC1_PAYLOAD_LOOP = 1;
	localparam int CC1_FRAMER_LOOP = 0;
	// channel byte bit indices (bit 1 is the msb of a channel)
	localparam int BIT_SEVEN_IDX = 1;
	localparam int BIT_TWO_IDX = 6;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	// transmit clock loss detection timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int TX_CLOCK_LOSS_NS = 2000;
	localparam int LOSS_COUNT_W = 7;
	localparam logic [LOSS_COUNT_W-1:0] TX_CLOCK_LOSS_CYCLES =
		LOSS_COUNT_W'((TX_CLOCK_LOSS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	// output pin test modes
	typedef enum logic [1:0] {
		TEST_NORMAL = 2'h0,
		TEST_TRISTATE = 2'h1,
		TEST_DRIVE_LOW = 2'h2,
		TEST_DRIVE_HIGH = 2'h3
	} test_mode_t;
	// transmit sync pulse generator states
	typedef enum logic [1:0] {
		SYNC_IDLE = 2'h0,
		SYNC_PULSE = 2'h1,
		SYNC_EXTEND = 2'h3
	} tx_sync_state_t;
endpackage

// file: src/t1_transmit_common_control.sv
// transmit control, common control registers and the loopback and pin logic they steer
`timescale 1ns/10ps
module t1_transmit_common_control (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [7:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic bus_write,
	input wire logic bus_read,
	output logic [7:0] bus_rdata,
	output logic bus_rdata_valid,
	output logic bus_data_oe,
	input wire logic transmit_clock_input,
	input wire logic transmit_serial_data_in,
	input wire logic line_in_positive,
	input wire logic line_in_negative,
	input wire logic transmit_sync_pin_in,
	input wire logic tx_bit_strobe,
	input wire logic tx_frame_start,
	input wire logic tx_multiframe_start,
	input wire logic tx_signaling_frame,
	input wire logic tx_line_pos,
	input wire logic tx_line_neg,
	input wire logic rx_recovered_pos,
	input wire logic rx_recovered_neg,
	input wire logic rx_serial_bit,
	input wire logic rx_signaling_slot,
	input wire logic yellow_alarm_request,
	input wire logic [7:0] tx_byte,
	input wire logic tx_byte_valid,
	output logic tx_clock_from_rx,
	output logic frame_bits_internal,
	output logic zbtsi_en,
	output logic yellow_bit2_force,
	output logic yellow_sbit_f12,
	output logic tx_elastic_en,
	output logic rx_elastic_en,
	output logic system_clock_rate_select,
	output logic tx_payload_from_rx,
	output logic rx_clock_from_tx,
	output logic tx_serial_to_formatter,
	output logic rx_line_to_framer_pos,
	output logic rx_line_to_framer_neg,
	output logic [7:0] tx_stuffed_byte,
	output logic tx_stuffed_valid,
	output logic transmit_sync_out,
	output logic transmit_sync_oe,
	output logic tx_sync_in_level,
	output logic line_out_positive,
	output logic line_out_negative,
	output logic line_out_oe,
	output logic receive_serial_data_out,
	output logic receive_serial_oe
);
	localparam int PIN_COUNT = 5; // pins that need synchronising

	// register index decode shared by write and read paths
	function automatic logic [1:0] reg_select(input logic [7:0] addr);
		if (addr == t1_ctrl_pkg::TX_CTRL_ONE_ADDR) begin
			return 2'h1;
		end else if (addr == t1_ctrl_pkg::TX_CTRL_TWO_ADDR) begin
			return 2'h2;
		end else if (addr == t1_ctrl_pkg::COMMON_CTRL_ONE_ADDR) begin
			return 2'h3;
		end else begin
			return 2'h0;
		end
	endfunction

	// test mode override of one pin: returns {value, enable}
	function automatic logic [1:0] pin_test(input t1_ctrl_pkg::test_mode_t mode,
		input logic value, input logic enable);
		case (mode)
			t1_ctrl_pkg::TEST_TRISTATE: return {value, 1'b0};
			t1_ctrl_pkg::TEST_DRIVE_LOW: return 2'b01;
			t1_ctrl_pkg::TEST_DRIVE_HIGH: return 2'b11;
			default: return {value, enable};
		endcase
	endfunction

	logic [7:0] transmit_control_one; // clock fallback, frame bit source
	logic [7:0] transmit_control_two; // test, sync, yellow, stuffing
	logic [7:0] common_control_one; // elastic stores, loopbacks
	logic [7:0] next_tc1;
	logic [7:0] next_tc2;
	logic [7:0] next_cc1;
	logic [7:0] next_rdata;
	logic next_rdata_valid;
	logic next_data_oe;
	t1_ctrl_pkg::test_mode_t test_mode; // decoded output test mode

	assign test_mode = t1_ctrl_pkg::test_mode_t'({transmit_control_two[t1_ctrl_pkg::TC2_TEST_HI],
		transmit_control_two[t1_ctrl_pkg::TC2_TEST_LO]});

	// host writes store the whole byte
	always_comb begin
		next_tc1 = transmit_control_one;
		next_tc2 = transmit_control_two;
		next_cc1 = common_control_one;
		if (bus_write) begin
			case (reg_select(bus_addr))
				2'h1: next_tc1 = bus_wdata; // R20
				2'h2: next_tc2 = bus_wdata; // R20
				2'h3: next_cc1 = bus_wdata; // R20
				default: next_tc1 = transmit_control_one; // unmapped write ignored
			endcase
		end
	end

	// host reads return the stored byte, unmapped reads zero
	always_comb begin
		next_rdata_valid = bus_read;
		next_data_oe = bus_read && (test_mode != t1_ctrl_pkg::TEST_TRISTATE); // R10
		next_rdata = bus_rdata;
		if (bus_read) begin
			case (reg_select(bus_addr))
				2'h1: next_rdata = transmit_control_one; // R20
				2'h2: next_rdata = transmit_control_two; // R20
				2'h3: next_rdata = common_control_one; // R20
				default: next_rdata = t1_ctrl_pkg::UNMAPPED_READ;
			endcase
		end
	end

	// register bank and read port
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			transmit_control_one <= t1_ctrl_pkg::REG_RESET;
			transmit_control_two <= t1_ctrl_pkg::REG_RESET;
			common_control_one <= t1_ctrl_pkg::REG_RESET;
			bus_rdata <= t1_ctrl_pkg::UNMAPPED_READ;
			bus_rdata_valid <= 1'b0;
			bus_data_oe <= 1'b0;
		end else begin
			transmit_control_one <= next_tc1;
			transmit_control_two <= next_tc2;
			common_control_one <= next_cc1;
			bus_rdata <= next_rdata;
			bus_rdata_valid <= next_rdata_valid;
			bus_data_oe <= next_data_oe;
		end
	end

	// two-stage synchronisers for the asynchronous pins
	logic [PIN_COUNT-1:0] pin_raw;
	logic [PIN_COUNT-1:0] pin_meta; // first stage, read only by second
	logic [PIN_COUNT-1:0] pin_sync; // second stage, safe to use
	assign pin_raw = {transmit_sync_pin_in, line_in_negative, line_in_positive,
		transmit_serial_data_in, transmit_clock_input};
	generate
		for (genvar i = 0; i < PIN_COUNT; i++) begin : g_sync
			always_ff @(posedge sys_clk) begin
				if (!reset_n) begin
					pin_meta[i] <= 1'b0;
					pin_sync[i] <= 1'b0;
				end else begin
					pin_meta[i] <= pin_raw[i];
					pin_sync[i] <= pin_meta[i];
				end
			end
		end
	endgenerate

	// watch the transmit clock for stalls
	logic tx_clock_lost;
	transmit_activity_monitor u_tx_clock_watch (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.clock_level(pin_sync[0]),
		.clock_lost(tx_clock_lost)
	);

	// field views
	logic fallback_en, remote_loop, framer_loop, local_loop, payload_loop, sig_ones;
	assign fallback_en = transmit_control_one[t1_ctrl_pkg::TC1_CLOCK_FALLBACK];
	assign remote_loop = common_control_one[t1_ctrl_pkg::CC1_REMOTE_LOOP];
	assign framer_loop = common_control_one[t1_ctrl_pkg::CC1_FRAMER_LOOP];
	assign local_loop = common_control_one[t1_ctrl_pkg::CC1_LOCAL_LOOP];
	assign payload_loop = common_control_one[t1_ctrl_pkg::CC1_PAYLOAD_LOOP];
	assign sig_ones = common_control_one[t1_ctrl_pkg::CC1_RX_SIG_ONES];

	// transmit sync pulse generator
	t1_ctrl_pkg::tx_sync_state_t sync_state;
	t1_ctrl_pkg::tx_sync_state_t next_sync_state;
	logic sync_boundary; // selected boundary for this bit time
	always_comb begin
		sync_boundary = transmit_control_two[t1_ctrl_pkg::TC2_SYNC_MODE] ?
			tx_multiframe_start : tx_frame_start; // R6
		next_sync_state = sync_state;
		case (sync_state)
			t1_ctrl_pkg::SYNC_IDLE: begin
				if (tx_bit_strobe && sync_boundary) begin
					next_sync_state = t1_ctrl_pkg::SYNC_PULSE;
				end
			end
			t1_ctrl_pkg::SYNC_PULSE: begin
				if (tx_bit_strobe) begin
					// second bit time only in signaling frames
					if (transmit_control_two[t1_ctrl_pkg::TC2_SYNC_DOUBLE] && tx_signaling_frame) begin
						next_sync_state = t1_ctrl_pkg::SYNC_EXTEND; // R4
					end else begin
						next_sync_state = t1_ctrl_pkg::SYNC_IDLE;
					end
				end
			end
			t1_ctrl_pkg::SYNC_EXTEND: begin
				if (tx_bit_strobe) begin
					next_sync_state = t1_ctrl_pkg::SYNC_IDLE;
				end
			end
			default: next_sync_state = t1_ctrl_pkg::SYNC_IDLE;
		endcase
	end

	// sync state register
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			sync_state <= t1_ctrl_pkg::SYNC_IDLE;
		end else begin
			sync_state <= next_sync_state;
		end
	end

	// bit seven stuffing of all-zero channel bytes
	logic [7:0] next_stuffed_byte;
	logic next_stuffed_valid;
	always_comb begin
		next_stuffed_valid = tx_byte_valid;
		next_stuffed_byte = tx_stuffed_byte;
		if (tx_byte_valid) begin
			next_stuffed_byte = tx_byte;
			if (transmit_control_two[t1_ctrl_pkg::TC2_B7_SUPPRESS] &&
				tx_byte == t1_ctrl_pkg::ZERO_BYTE) begin
				next_stuffed_byte[t1_ctrl_pkg::BIT_SEVEN_IDX] = 1'b1; // R9
			end
			if (yellow_bit2_force) begin
				next_stuffed_byte[t1_ctrl_pkg::BIT_TWO_IDX] = 1'b0; // R8
			end
		end
	end

	// loopback muxes, configuration levels and pin drivers
	logic ones_phase; // alternates marks for the all-ones pattern
	logic next_ones_phase;
	logic [1:0] next_sync_pin, next_lpos, next_lneg, next_receive_serial_data_out;
	logic next_lpos_val, next_lneg_val;
	always_comb begin
		next_ones_phase = ones_phase ^ tx_bit_strobe;
		if (remote_loop) begin
			next_lpos_val = rx_recovered_pos; // R17
			next_lneg_val = rx_recovered_neg; // R17
		end else if (framer_loop) begin
			next_lpos_val = ~ones_phase; // R19
			next_lneg_val = ones_phase; // R19
		end else begin
			next_lpos_val = tx_line_pos; // R16
			next_lneg_val = tx_line_neg;
		end
		next_sync_pin = pin_test(test_mode, sync_state != t1_ctrl_pkg::SYNC_IDLE,
			transmit_control_two[t1_ctrl_pkg::TC2_SYNC_DIR]); // R7 R10 R11
		next_lpos = pin_test(test_mode, next_lpos_val, 1'b1); // R10 R11
		next_lneg = pin_test(test_mode, next_lneg_val, 1'b1); // R10 R11
		next_receive_serial_data_out = pin_test(test_mode, rx_serial_bit | (sig_ones & rx_signaling_slot), 1'b1); // R14
	end

	// output registers
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			ones_phase <= 1'b0;
			tx_clock_from_rx <= 1'b0;
			frame_bits_internal <= 1'b1;
			zbtsi_en <= 1'b0;
			yellow_bit2_force <= 1'b0;
			yellow_sbit_f12 <= 1'b0;
			tx_elastic_en <= 1'b0;
			rx_elastic_en <= 1'b0;
			system_clock_rate_select <= 1'b0;
			tx_payload_from_rx <= 1'b0;
			rx_clock_from_tx <= 1'b0;
			tx_serial_to_formatter <= 1'b0;
			rx_line_to_framer_pos <= 1'b0;
			rx_line_to_framer_neg <= 1'b0;
			tx_stuffed_byte <= t1_ctrl_pkg::ZERO_BYTE;
			tx_stuffed_valid <= 1'b0;
			transmit_sync_out <= 1'b0;
			transmit_sync_oe <= 1'b0;
			tx_sync_in_level <= 1'b0;
			{line_out_positive, line_out_oe} <= 2'b00;
			line_out_negative <= 1'b0;
			{receive_serial_data_out, receive_serial_oe} <= 2'b00;
		end else begin
			ones_phase <= next_ones_phase;
			tx_clock_from_rx <= (fallback_en & tx_clock_lost) | payload_loop; // R1 R18
			frame_bits_internal <= ~transmit_control_one[t1_ctrl_pkg::TC1_FRAME_PASSTHRU]; // R2
			zbtsi_en <= transmit_control_two[t1_ctrl_pkg::TC2_ZBTSI]; // R3
			yellow_bit2_force <= yellow_alarm_request &
				~transmit_control_two[t1_ctrl_pkg::TC2_YELLOW_STYLE]; // R8
			yellow_sbit_f12 <= yellow_alarm_request &
				transmit_control_two[t1_ctrl_pkg::TC2_YELLOW_STYLE]; // R8
			tx_elastic_en <= common_control_one[t1_ctrl_pkg::CC1_TX_ELASTIC]; // R12
			rx_elastic_en <= common_control_one[t1_ctrl_pkg::CC1_RX_ELASTIC]; // R13
			system_clock_rate_select <= common_control_one[t1_ctrl_pkg::CC1_CLOCK_RATE];
			tx_payload_from_rx <= payload_loop; // R18
			rx_clock_from_tx <= framer_loop; // R19
			tx_serial_to_formatter <= pin_sync[1] & ~(remote_loop | payload_loop); // R17 R18
			rx_line_to_framer_pos <= (local_loop | framer_loop) ? tx_line_pos : pin_sync[2]; // R16 R19
			rx_line_to_framer_neg <= (local_loop | framer_loop) ? tx_line_neg : pin_sync[3]; // R16 R19
			tx_stuffed_byte <= next_stuffed_byte;
			tx_stuffed_valid <= next_stuffed_valid;
			{transmit_sync_out, transmit_sync_oe} <= next_sync_pin;
			tx_sync_in_level <= pin_sync[4] & ~transmit_control_two[t1_ctrl_pkg::TC2_SYNC_DIR]; // R7
			{line_out_positive, line_out_oe} <= next_lpos;
			line_out_negative <= next_lneg[1];
			{receive_serial_data_out, receive_serial_oe} <= next_receive_serial_data_out;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	sequence sync_start_s;
		sync_state == t1_ctrl_pkg::SYNC_IDLE && tx_bit_strobe && sync_boundary;
	endsequence
	sequence double_wide_s;
		sync_state == t1_ctrl_pkg::SYNC_PULSE && tx_bit_strobe && tx_signaling_frame &&
			transmit_control_two[t1_ctrl_pkg::TC2_SYNC_DOUBLE];
	endsequence

	clock_fallback_a: assert property (fallback_en && tx_clock_lost |=> tx_clock_from_rx) // R1
		else $error("formatter did not fall back to receive clock");
	frame_source_a: assert property (bus_write && bus_addr == t1_ctrl_pkg::TX_CTRL_ONE_ADDR && // R2
		!bus_wdata[t1_ctrl_pkg::TC1_FRAME_PASSTHRU] |=> ##1 frame_bits_internal)
		else $error("frame bits not sourced internally");
	zbtsi_follow_a: assert property (bus_write && bus_addr == t1_ctrl_pkg::TX_CTRL_TWO_ADDR // R3
		|=> ##1 zbtsi_en == $past(bus_wdata[t1_ctrl_pkg::TC2_ZBTSI], 2))
		else $error("interchange enable does not follow write");
	sync_double_a: assert property (double_wide_s |=> sync_state == t1_ctrl_pkg::SYNC_EXTEND) // R4
		else $error("double-wide sync not extended");
	sync_mode_a: assert property (sync_start_s |=> sync_state == t1_ctrl_pkg::SYNC_PULSE) // R6
		else $error("sync pulse not started on selected boundary");
	sync_input_a: assert property (!transmit_control_two[t1_ctrl_pkg::TC2_SYNC_DIR] && // R7
		test_mode == t1_ctrl_pkg::TEST_NORMAL |=> !transmit_sync_oe)
		else $error("sync pin driven while an input");
	yellow_style_a: assert property (yellow_alarm_request |=> // R8
		yellow_bit2_force != yellow_sbit_f12)
		else $error("yellow alarm style not exclusive");
	stuff_zero_a: assert property (tx_byte_valid && tx_byte == t1_ctrl_pkg::ZERO_BYTE && // R9
		transmit_control_two[t1_ctrl_pkg::TC2_B7_SUPPRESS] |=>
		tx_stuffed_byte[t1_ctrl_pkg::BIT_SEVEN_IDX])
		else $error("bit seven not stuffed");
	test_float_a: assert property (test_mode == t1_ctrl_pkg::TEST_TRISTATE |=> // R10
		!line_out_oe && !receive_serial_oe && !transmit_sync_oe && !bus_data_oe)
		else $error("pins not floated in test mode");
	test_drive_a: assert property (test_mode == t1_ctrl_pkg::TEST_DRIVE_HIGH |=> // R11
		line_out_oe && line_out_positive && line_out_negative && transmit_sync_out)
		else $error("pins not driven high in test mode");
	sig_ones_a: assert property (sig_ones && rx_signaling_slot && test_mode == // R14
		t1_ctrl_pkg::TEST_NORMAL |=> receive_serial_data_out)
		else $error("signaling bit not forced to one");
	remote_loop_a: assert property (remote_loop && test_mode == t1_ctrl_pkg::TEST_NORMAL // R17
		|=> line_out_positive == $past(rx_recovered_pos) && !tx_serial_to_formatter)
		else $error("remote loopback not retransmitting");
	framer_ones_a: assert property (framer_loop && !remote_loop && test_mode == // R19
		t1_ctrl_pkg::TEST_NORMAL |=> line_out_positive != line_out_negative)
		else $error("framer loopback not sending ones");
	read_back_a: assert property (bus_write && bus_addr == t1_ctrl_pkg::COMMON_CTRL_ONE_ADDR // R20
		##1 (bus_read && !bus_write && bus_addr == t1_ctrl_pkg::COMMON_CTRL_ONE_ADDR)
		|=> bus_rdata_valid && bus_rdata == $past(bus_wdata, 2))
		else $error("register does not read back");
endmodule

// file: src/transmit_activity_monitor.sv
// watchdog that flags a stalled transmit clock
`timescale 1ns/10ps
module transmit_activity_monitor (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic clock_level,
	output logic clock_lost
);
	logic prev_level; // last sampled level
	logic [t1_ctrl_pkg::LOSS_COUNT_W-1:0] idle_count; // cycles since an edge
	logic next_prev_level;
	logic [t1_ctrl_pkg::LOSS_COUNT_W-1:0] next_idle_count;
	logic next_clock_lost;

	// any change restarts the count; saturate at the loss threshold
	always_comb begin
		next_prev_level = clock_level;
		next_idle_count = idle_count;
		next_clock_lost = clock_lost;
		if (clock_level != prev_level) begin
			next_idle_count = '0;
			next_clock_lost = 1'b0;
		end else if (idle_count == t1_ctrl_pkg::TX_CLOCK_LOSS_CYCLES) begin
			next_clock_lost = 1'b1;
		end else begin
			next_idle_count = idle_count + 1'b1;
		end
	end

	// state registers
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			prev_level <= 1'b0;
			idle_count <= '0;
			clock_lost <= 1'b0;
		end else begin
			prev_level <= next_prev_level;
			idle_count <= next_idle_count;
			clock_lost <= next_clock_lost;
		end
	end
endmodule
